// ===== sfmtg_gen.sv
// Traffic generator: LFSR stream source and numbered flow message source
`timescale 1ns/1ns
`default_nettype none
module sfmtg_gen #(
  parameter int unsigned LANES = sfmtg_pkg::DEF_LANES,
  parameter int unsigned GAP   = sfmtg_pkg::DEF_GAP
) (
  sfmtg_link_if.gen lnk,
  output logic      [7:0] msg_count,
  output logic            busy
);
  import sfmtg_pkg::*;
  localparam int unsigned DW  = LANE_BITS * LANES;
  localparam int unsigned BPW = BYTES_PER_LANE * LANES;

  initial begin
    if (LANES < 1 || LANES > 16 || GAP < 1 || GAP > 65535)
      $error("unsupported lane count or gap");
  end

  typedef enum logic [3:0] {
    SFMTG_IDLE = 4'b0001,
    SFMTG_REQ  = 4'b0010,
    SFMTG_DATA = 4'b0100,
    SFMTG_GAP  = 4'b1000
  } sfmtg_state_e;

  // Stream source: LFSR words buffered through the FIFO
  logic [63:0]   lfsr_ff, nxt_lfsr;
  logic [DW-1:0] word;
  logic          fifo_in_ready;
  logic          op;

  assign op = lnk.link_up && !lnk.rst;

  // One 64-bit LFSR step per lane, lanes taken from successive states
  always_comb begin
    logic [63:0] s;
    s = lfsr_ff;
    word = '0;
    for (int i = 0; i < int'(LANES); i++) begin
      word[DW-1-i*64 -: 64] = s;
      s = {s[62:0], ^(s & LFSR_TAPS)};
    end
    nxt_lfsr = (op && fifo_in_ready) ? s : lfsr_ff;
  end

  always_ff @(posedge lnk.sys_clk) begin
    if (lnk.rst) begin
      lfsr_ff <= LFSR_SEED;
    end else begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  logic fifo_out_valid;

  // FIFO pops only on stream ready, so core stalls back-press the LFSR
  sfmtg_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (lnk.sys_clk),
    .rst       (lnk.rst),
    .in_data   (word),
    .in_valid  (op),
    .in_ready  (fifo_in_ready),
    .out_data  (lnk.tx_data),
    .out_valid (fifo_out_valid),
    .out_ready (lnk.tx_ready && lnk.link_up)
  );
  // Valid stays high while the link is up once words flow; the FIFO never runs dry
  assign lnk.tx_valid = fifo_out_valid && lnk.link_up;

  // Flow message sequencer
  sfmtg_state_e  st_ff, nxt_st;
  logic [7:0]    size_ff, nxt_size;
  logic [8:0]    left_ff, nxt_left;
  logic [15:0]   gap_ff, nxt_gap;
  logic [7:0]    cnt_ff, nxt_cnt;
  logic [DW-1:0] mdata_ff, nxt_mdata;
  logic          beat;

  assign beat = lnk.msg_valid && lnk.msg_ready;

  always_comb begin
    nxt_st    = st_ff;
    nxt_size  = size_ff;
    nxt_left  = left_ff;
    nxt_gap   = gap_ff;
    nxt_cnt   = cnt_ff;
    nxt_mdata = mdata_ff;
    case (st_ff)
      SFMTG_IDLE: begin
        if (op) begin
          nxt_st   = SFMTG_REQ;
          nxt_left = 9'(size_ff) + 9'h001;
        end
      end
      SFMTG_REQ: begin
        nxt_st = SFMTG_DATA;
        // Payload: message number repeated, bytes counted from the left
        nxt_mdata = {BPW{size_ff}};
      end
      SFMTG_DATA: begin
        if (beat) begin
          if (left_ff <= 9'(BPW)) begin
            nxt_st   = SFMTG_GAP;
            nxt_gap  = 16'(GAP);
            nxt_left = '0;
            nxt_cnt  = cnt_ff + 8'h01;
            // Wraps to zero past the maximum
            nxt_size = (size_ff == MS_MAX) ? MS_FIRST
                                           : size_ff + 8'h01;
          end else begin
            nxt_left = left_ff - 9'(BPW);
          end
        end
      end
      SFMTG_GAP: begin
        if (gap_ff <= 16'h0001) begin
          nxt_st = SFMTG_IDLE;
        end else begin
          nxt_gap = gap_ff - 16'h0001;
        end
      end
      default: nxt_st = SFMTG_IDLE;
    endcase
    if (!lnk.link_up) begin
      nxt_st = SFMTG_IDLE;
    end
  end

  always_ff @(posedge lnk.sys_clk) begin
    if (lnk.rst) begin
      st_ff    <= SFMTG_IDLE;
      size_ff  <= MS_FIRST;
      left_ff  <= '0;
      gap_ff   <= '0;
      cnt_ff   <= 8'h00;
      mdata_ff <= '0;
    end else begin
      st_ff    <= nxt_st;
      size_ff  <= nxt_size;
      left_ff  <= nxt_left;
      gap_ff   <= nxt_gap;
      cnt_ff   <= nxt_cnt;
      mdata_ff <= nxt_mdata;
    end
  end

  // Request is a one-cycle pulse with the size beside it
  assign lnk.flow_msg_req  = (st_ff == SFMTG_REQ);
  assign lnk.flow_msg_size = size_ff;
  assign lnk.msg_valid     = (st_ff == SFMTG_DATA);
  assign lnk.msg_data      = mdata_ff;
  assign msg_count         = cnt_ff;
  assign busy              = (st_ff != SFMTG_IDLE);
endmodule
`default_nettype wire

// ===== sfmtg_pkg.sv
// Shared constants for the stream and flow message traffic pair
package sfmtg_pkg;
  localparam int unsigned LANE_BITS      = 64;
  localparam int unsigned DEF_LANES      = 1;
  localparam int unsigned MS_W           = 8;
  localparam logic [7:0]  MS_MAX         = 8'hFF;
  localparam logic [7:0]  MS_FIRST       = 8'h00;
  localparam int unsigned DEF_GAP        = 16;
  localparam int unsigned FIFO_DEPTH     = 32;
  localparam logic [63:0] LFSR_SEED      = 64'hACE1_2468_1357_9BDF;
  // Taps 64,63,61,60 give a maximal-length sequence
  localparam logic [63:0] LFSR_TAPS      = 64'hD800_0000_0000_0000;
  localparam int unsigned CORE_RDY_DELAY = 1;
  localparam int unsigned BYTES_PER_LANE = 8;
endpackage

// ===== sfmtg_link_if.sv
// Interface joining the traffic generator and the link core transmit side
`timescale 1ns/1ns
`default_nettype none
interface sfmtg_link_if #(
  parameter int unsigned LANES = sfmtg_pkg::DEF_LANES
) (
  input wire logic sys_clk
);
  localparam int unsigned DW = sfmtg_pkg::LANE_BITS * LANES;
  logic          rst;
  logic          link_up;
  logic [DW-1:0] tx_data;
  logic          tx_valid;
  logic          tx_ready;
  logic          flow_msg_req;
  logic [7:0]    flow_msg_size;
  logic [DW-1:0] msg_data;
  logic          msg_valid;
  logic          msg_ready;

  modport gen (
    input  sys_clk, rst, link_up, tx_ready, msg_ready,
    output tx_data, tx_valid, flow_msg_req, flow_msg_size, msg_data,
    msg_valid
  );
  modport core (
    input  sys_clk, tx_data, tx_valid, flow_msg_req, flow_msg_size,
    msg_data, msg_valid,
    output rst, link_up, tx_ready, msg_ready
  );
endinterface
`default_nettype wire

// ===== sfmtg_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sfmtg_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = sfmtg_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import sfmtg_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  // Flags straight from the fill count; count is one bit wider than pointers
  assign in_ready  = (cnt_ff < (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count next state
  always_comb begin
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop  ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage holds no reset; only written entries are ever read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== sfmtg_core.sv
// Link core transmit end: accepts stream words and flow messages
`timescale 1ns/1ns
`default_nettype none
module sfmtg_core #(
  parameter int unsigned LANES = sfmtg_pkg::DEF_LANES
) (
  sfmtg_link_if.core lnk,
  input  wire logic                 rst,
  input  wire logic                 link_up,
  input  wire logic                 prio_busy,
  input  wire logic                 sink_stall,
  output logic [sfmtg_pkg::LANE_BITS*LANES-1:0] rx_word,
  output logic                      rx_word_stb,
  output logic [sfmtg_pkg::LANE_BITS*LANES-1:0] rx_msg,
  output logic                      rx_msg_stb,
  output logic                      rx_msg_last,
  output logic                      idle_ins
);
  import sfmtg_pkg::*;
  localparam int unsigned DW  = LANE_BITS * LANES;
  localparam int unsigned BPW = BYTES_PER_LANE * LANES;

  initial begin
    if (LANES < 1 || LANES > 16)
      $error("unsupported lane count");
  end

  logic          pend_ff, nxt_pend;
  logic          act_ff, nxt_act;
  logic [8:0]    left_ff, nxt_left;
  logic [DW-1:0] word_ff, nxt_word, msg_ff, nxt_msg;
  logic          wstb_ff, nxt_wstb, mstb_ff, nxt_mstb, last_ff, nxt_last;
  logic          idle_ff, nxt_idle;
  logic          mrdy, mbeat;

  assign lnk.rst     = rst;
  assign lnk.link_up = link_up;
  // Ready one cycle after request; dropped for priority work
  assign mrdy          = act_ff && !prio_busy;
  assign lnk.msg_ready = mrdy;
  assign lnk.tx_ready  = link_up && !mrdy && !sink_stall;
  assign mbeat         = lnk.msg_valid && mrdy;

  // Request capture and message byte tracking
  always_comb begin
    nxt_pend = pend_ff;
    nxt_act  = act_ff;
    nxt_left = left_ff;
    nxt_msg  = msg_ff;
    nxt_mstb = 1'b0;
    nxt_last = 1'b0;
    nxt_idle = act_ff && mrdy && !lnk.msg_valid;
    if (lnk.flow_msg_req) begin
      nxt_pend = 1'b1;
    end
    // Request starts at once when idle, else on the current last beat
    if ((pend_ff || lnk.flow_msg_req)
        && (!act_ff || (mbeat && left_ff <= 9'(BPW)))) begin
      nxt_pend = pend_ff && lnk.flow_msg_req;
      nxt_act  = 1'b1;
      nxt_left = 9'(lnk.flow_msg_size) + 9'h001;
    end else if (mbeat) begin
      if (left_ff <= 9'(BPW)) begin
        nxt_act = 1'b0;
      end
      nxt_left = (left_ff <= 9'(BPW)) ? 9'h000 : left_ff - 9'(BPW);
    end
    if (mbeat) begin
      // Keep only leftmost bytes on the final beat
      for (int b = 0; b < int'(BPW); b++) begin
        nxt_msg[DW-1-b*8 -: 8] = (9'(b) < left_ff)
                                 ? lnk.msg_data[DW-1-b*8 -: 8] : 8'h00;
      end
      nxt_mstb = 1'b1;
      nxt_last = (left_ff <= 9'(BPW));
    end
    nxt_word = word_ff;
    nxt_wstb = lnk.tx_valid && lnk.tx_ready;
    if (nxt_wstb) begin
      nxt_word = lnk.tx_data;
    end
  end

  always_ff @(posedge lnk.sys_clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      act_ff  <= 1'b0;
      left_ff <= '0;
      word_ff <= '0;
      msg_ff  <= '0;
      wstb_ff <= 1'b0;
      mstb_ff <= 1'b0;
      last_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      act_ff  <= nxt_act;
      left_ff <= nxt_left;
      word_ff <= nxt_word;
      msg_ff  <= nxt_msg;
      wstb_ff <= nxt_wstb;
      mstb_ff <= nxt_mstb;
      last_ff <= nxt_last;
      idle_ff <= nxt_idle;
    end
  end

  assign rx_word     = word_ff;
  assign rx_word_stb = wstb_ff;
  assign rx_msg      = msg_ff;
  assign rx_msg_stb  = mstb_ff;
  assign rx_msg_last = last_ff;
  assign idle_ins    = idle_ff;
endmodule
`default_nettype wire

// ===== sfmtg_link_sva.sv
// Assertion checker watching the generator to core link signals
`timescale 1ns/1ns
`default_nettype none
module sfmtg_link_sva
  import sfmtg_pkg::*;
#(
  parameter int unsigned LANES = 1,
  parameter int unsigned GAP   = 16
) (
  input wire logic                                 sys_clk,
  input wire logic                                 rst,
  input wire logic                                 link_up,
  input wire logic [sfmtg_pkg::LANE_BITS*LANES-1:0] tx_data,
  input wire logic                                 tx_valid,
  input wire logic                                 tx_ready,
  input wire logic                                 flow_msg_req,
  input wire logic [7:0]                           flow_msg_size,
  input wire logic [sfmtg_pkg::LANE_BITS*LANES-1:0] msg_data,
  input wire logic                                 msg_valid,
  input wire logic                                 msg_ready
);
  logic [7:0]  last_sz_ff;
  logic        seen_ff;
  logic [16:0] idle_ff;

  // Remember last size and count quiet cycles since the last payload
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_ff <= 1'b0;
      last_sz_ff <= 8'h00;
      idle_ff <= 17'h00000;
    end else begin
      if (flow_msg_req) begin
        seen_ff <= 1'b1;
        last_sz_ff <= flow_msg_size;
      end
      // Saturate so a long idle stretch never wraps to a small count
      idle_ff <= msg_valid ? 17'h00000 : idle_ff + {16'h0000, ~&idle_ff};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_TX_HOLD: assert property (tx_valid && !tx_ready ##1 link_up
    |-> tx_valid && $stable(tx_data)) else $error("stream word dropped");
  AST_TX_ALWAYS: assert property (link_up && $past(link_up)
    && $past(link_up, 2) && !$past(rst) && !$past(rst, 2) |-> tx_valid)
    else $error("stream valid low while running");
  AST_REQ_LINK: assert property (flow_msg_req
    |-> link_up && $past(link_up)) else $error("request without link");
  AST_REQ_VALID: assert property (flow_msg_req
    |=> msg_valid && !flow_msg_req) else $error("no valid after request");
  AST_VALID_CAUSE: assert property ($rose(msg_valid)
    |-> $past(flow_msg_req)) else $error("valid without request");
  AST_SIZE_SEQ: assert property (flow_msg_req |-> flow_msg_size ==
    (seen_ff ? last_sz_ff + 8'h01 : MS_FIRST)) else $error("size order");
  AST_SIZE_HOLD: assert property (msg_valid
    |-> $stable(flow_msg_size)) else $error("size moved in message");
  AST_MSG_HOLD: assert property (msg_valid && !msg_ready ##1 link_up
    |-> msg_valid && $stable(msg_data)) else $error("payload dropped");
  AST_RDY_EXCL: assert property (msg_ready
    |-> !tx_ready) else $error("both readies high");
  AST_GAP: assert property (flow_msg_req && seen_ff
    |-> idle_ff >= 17'(GAP)) else $error("message gap too short");
endmodule
`default_nettype wire

// ===== stream_and_flow_msg_traffic_gen_tb.sv
// Self-checking bench for the traffic generator and link core pair
`timescale 1ns/1ns
`default_nettype none
module stream_and_flow_msg_traffic_gen_tb;
  import sfmtg_pkg::*;
  localparam int unsigned GAPV = 2;
  logic        sys_clk;
  logic        rst;
  logic        link_up;
  logic        prio_busy;
  logic        sink_stall;
  logic [63:0] rx_word;
  logic        rx_word_stb;
  logic [63:0] rx_msg;
  logic        rx_msg_stb;
  logic        rx_msg_last;
  logic        idle_ins;
  logic [7:0]  msg_count;
  logic        busy;
  int          n_errors;
  int          num_checks;

  sfmtg_link_if #(.LANES(1)) lnk (.sys_clk(sys_clk));
  sfmtg_gen #(.LANES(1), .GAP(GAPV)) i_sfmtg_gen (.lnk(lnk),
    .msg_count(msg_count), .busy(busy));
  sfmtg_core #(.LANES(1)) i_sfmtg_core (.lnk(lnk), .rst(rst),
    .link_up(link_up), .prio_busy(prio_busy), .sink_stall(sink_stall),
    .rx_word(rx_word), .rx_word_stb(rx_word_stb), .rx_msg(rx_msg),
    .rx_msg_stb(rx_msg_stb), .rx_msg_last(rx_msg_last),
    .idle_ins(idle_ins));
  sfmtg_link_sva #(.LANES(1), .GAP(GAPV)) i_sfmtg_link_sva (
    .sys_clk(sys_clk), .rst(lnk.rst), .link_up(lnk.link_up),
    .tx_data(lnk.tx_data), .tx_valid(lnk.tx_valid),
    .tx_ready(lnk.tx_ready), .flow_msg_req(lnk.flow_msg_req),
    .flow_msg_size(lnk.flow_msg_size), .msg_data(lnk.msg_data),
    .msg_valid(lnk.msg_valid), .msg_ready(lnk.msg_ready));

  // Free-running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [63:0] nxt_lfsr(input logic [63:0] s);
    return {s[62:0], ^(s & LFSR_TAPS)};
  endfunction

  // Reset for five cycles with the link down
  task automatic do_reset;
    rst = 1'b1;
    link_up = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(lnk.tx_valid === 1'b0 && lnk.msg_valid === 1'b0, "busy in reset");
    rst = 1'b0;
  endtask

  // Sequence check across a stall long enough to fill the buffer
  task automatic t_stream(input int n);
    logic [63:0] prev;
    int          got;
    int          cyc;
    got = 0;
    link_up = 1'b1;
    for (cyc = 0; cyc < 600 && got < n; cyc++) begin
      @(negedge sys_clk);
      sink_stall = (cyc >= 10 && cyc < 50);
      if (rx_word_stb === 1'b1) begin
        if (got > 0) chk(rx_word === nxt_lfsr(prev), "word order");
        else chk(rx_word === LFSR_SEED, "first word not seed");
        chk(cyc < 11 || cyc > 50, "word taken in stall");
        prev = rx_word;
        got++;
      end
    end
    chk(got >= n, "stream starved");
  endtask

  // Numbered messages through the size wrap, one under priority stall
  task automatic t_msgs(input int n);
    logic [7:0]  k;
    logic [63:0] exp;
    int          m;
    int          b;
    int          r;
    int          j;
    int          cyc;
    link_up = 1'b1;
    for (m = 0; m < n; m++) begin
      cyc = 0;
      do begin
        @(negedge sys_clk);
        cyc++;
      end while (lnk.flow_msg_req !== 1'b1 && cyc < 100);
      chk(lnk.flow_msg_req === 1'b1 && busy === 1'b1, "no request");
      k = lnk.flow_msg_size;
      chk(k === m[7:0] && msg_count === m[7:0], "size or count");
      prio_busy = (m == 5);
      b = 0;
      for (cyc = 0; cyc < 300; cyc++) begin
        @(negedge sys_clk);
        if (cyc == 0) chk(lnk.msg_ready === (m != 5), "ready late");
        chk(idle_ins === 1'b0, "idle inserted");
        if (cyc > 2) prio_busy = 1'b0;
        if (rx_msg_stb === 1'b1) begin
          r = int'(k) + 1 - 8 * b;
          for (j = 0; j < 8; j++) exp[63-8*j -: 8] = (j < r) ? k : 8'h00;
          chk(rx_msg === exp && rx_msg_last === (r <= 8), "beat");
          b++;
          if (r <= 8) break;
        end
      end
      chk(b == (int'(k) + 8) / 8, "beat count");
    end
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    #400000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    rst = 1'b1;
    link_up = 1'b0;
    prio_busy = 1'b0;
    sink_stall = 1'b0;
    do_reset();
    t_msgs(258);
    do_reset();
    t_stream(60);
    give_verdict();
  end
endmodule
`default_nettype wire
